// *** common/cidi_consts.vh ***
// Register offsets, field positions, reset values and codes of the CAN interrupt indicator.
`ifndef CIDI_CONSTS_VH
`define CIDI_CONSTS_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define CIDI_OFS_SOURCE_CODE 8'h00
`define CIDI_OFS_RX_ERR 8'h04
`define CIDI_OFS_TX_ERR 8'h08
`define CIDI_OFS_CONTROL 8'h0C
`define CIDI_OFS_STATUS 8'h10
`define CIDI_OFS_SLOT_BASE 8'h40
`define CIDI_OFS_EXT_IRQ_EN 8'hE8
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CIDI_CTL_SOFT_RESET 0
`define CIDI_CTL_ERROR_IRQ_EN 1
`define CIDI_CTL_STATUS_IRQ_EN 2
`define CIDI_EIE_CAN_B 5
`define CIDI_SLOT_READY 7
`define CIDI_SLOT_TX_EN 6
`define CIDI_SLOT_RX_EN 5
`define CIDI_SLOT_REQ 4
// ----------------------------------------------------------------------------
// Reset values and indicator codes
// ----------------------------------------------------------------------------
`define CIDI_RST_BYTE 8'h00
`define CIDI_CODE_NONE 8'h00
`define CIDI_CODE_STATUS 8'h01
`define CIDI_CODE_SLOT15 8'h02
`define CIDI_CODE_SLOT1 8'h03
`define CIDI_NUM_SLOTS 15
`endif

// *** rtl/cidi_slot.v ***
// One message slot control register: ready, interrupt enables and request flag.
`timescale 1ns/1ps
`include "cidi_consts.vh"
module cidi_slot #(
   parameter RX_ONLY = 0
) (
   input wire pclk,
   input wire presetn,
   input wire soft_reset,
   input wire wr_en,
   input wire [7:0] wdata,
   input wire tx_done,
   input wire rx_stored,
   output reg slot_ready,
   output reg slot_tx_irq_en,
   output reg slot_rx_irq_en,
   output reg slot_irq_request
);
   wire tx_set;
   wire rx_set;
   wire req_set;
   wire req_clr;

   // Events only count while the slot is ready; a slot that is not ready still keeps a request already set.
   assign tx_set = (RX_ONLY == 0) && slot_tx_irq_en && tx_done && slot_ready;
   assign rx_set = slot_rx_irq_en && rx_stored && slot_ready;
   assign req_set = tx_set || rx_set;
   // Software may only clear the request; writing a one leaves it alone.
   assign req_clr = wr_en && !wdata[`CIDI_SLOT_REQ];

   // ----------------------------------------------------------------------------
   // Control flops
   // ----------------------------------------------------------------------------
   // A new event wins over a clear in the same cycle so that no completion is lost.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_ready <= 1'b0;
         slot_tx_irq_en <= 1'b0;
         slot_rx_irq_en <= 1'b0;
         slot_irq_request <= 1'b0;
      end else if (soft_reset) begin
         slot_ready <= 1'b0;
         slot_tx_irq_en <= 1'b0;
         slot_rx_irq_en <= 1'b0;
         slot_irq_request <= 1'b0;
      end else begin
         if (wr_en) begin
            slot_ready <= wdata[`CIDI_SLOT_READY];
            slot_tx_irq_en <= wdata[`CIDI_SLOT_TX_EN];
            slot_rx_irq_en <= wdata[`CIDI_SLOT_RX_EN];
         end
         if (req_set) begin
            slot_irq_request <= 1'b1;
         end else if (req_clr) begin
            slot_irq_request <= 1'b0;
         end
      end
   end
endmodule // cidi_slot

// *** rtl/cidi_indicator.v ***
// CAN interrupt source indicator with APB register access and fifteen message slots.
//
// Operation
// - Codes: 00h none, 01h status change, 02h slot 15, 03h-10h slots 1-14.
// - Indicator register clears to zero on reset.
// - Displayed code holds until its source is acknowledged and removed.
// - Status read acknowledges status change; clearing slot request acknowledges a slot.
// - Simultaneous new sources while idle: higher priority one is displayed.
// - Interrupt request is active whenever the indicator is non-zero; here it follows the indicator one cycle later.
// - After clearing, indicator shows highest remaining active source or zero.
// - Status change counts only when changed, enabled, and internal state set.
// - A slot is an active source whenever its request bit is set.
// - Receive error count accumulates; transmit error count writes load it too.
// - Receive error count clears on hardware reset and CAN soft reset.
// - Extended enable bit five gates the CAN B interrupt; all bits reset zero.
// - A slot whose ready bit is zero takes part in no activity; here it only ignores new events, and a request already set stays active.
// - Slot ready bits clear on hardware reset and CAN soft reset.
// - Transmit enable lets a successful transmission set the slot request.
// - Receive enable lets a stored reception set the slot request.
// - Any status register read clears the pending status change.
`timescale 1ns/1ps
`include "cidi_consts.vh"
module cidi_indicator #(
   parameter ADDR_W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   input wire [7:0] can_status_reg,
   input wire status_change_evt,
   input wire error_change_evt,
   input wire rx_error_inc,
   input wire [14:0] slot_tx_done,
   input wire [14:0] slot_rx_stored,
   output wire [14:0] slot_ready,
   output wire can_soft_reset,
   output reg can_irq_request,
   output reg can_b_irq
);
   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   reg [7:0] extended_irq_enable;
   reg [7:0] can_irq_source_code;
   reg [7:0] rx_error_count;
   reg [7:0] tx_error_count;
   reg [7:0] control;
   reg status_pending;
   reg [7:0] next_code;
   reg [7:0] rd_byte;
   reg rd_hit;
   reg displayed_active;
   wire setup;
   wire access;
   wire wr_access;
   wire rd_access;
   wire lane0;
   wire [5:0] word_idx;
   wire [5:0] slot_base_idx;
   wire in_slot_range;
   wire [3:0] slot_num;
   wire [14:0] slot_wr;
   wire [14:0] slot_tx_en;
   wire [14:0] slot_rx_en;
   wire [14:0] slot_req;
   wire error_irq_en;
   wire status_irq_en;
   wire status_raise;
   wire status_read;
   wire [7:0] slot_base_ofs;
   wire [5:0] slot_ofs;
   wire wr_any;
   wire wr_ext;
   wire wr_ctl;
   wire wr_txerr;
   wire code_nonzero;
   // Each combinational loop has its own index so no variable has two drivers.
   integer i_pri;
   integer i_act;
   integer i_rd;

   // ----------------------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------------------
   // Zero wait states: read data is captured during setup so it is stable in access.
   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_access = access && pwrite;
   assign rd_access = access && !pwrite;
   // Only the low byte lane carries register data; other lanes are ignored.
   assign lane0 = pstrb[0];
   assign word_idx = paddr[7:2];
   assign slot_base_ofs = `CIDI_OFS_SLOT_BASE;
   assign slot_base_idx = slot_base_ofs[7:2];
   assign in_slot_range = (word_idx >= slot_base_idx) &&
                          (word_idx < slot_base_idx + `CIDI_NUM_SLOTS);
   // Slot number 1..15 from the word index.
   assign slot_ofs = word_idx - slot_base_idx + 6'h01;
   assign slot_num = slot_ofs[3:0];

   // Write strobes of the plain registers; a write with the low lane off is dropped.
   assign wr_any = wr_access && lane0;
   assign wr_ext = wr_any && (paddr[7:0] == `CIDI_OFS_EXT_IRQ_EN);
   assign wr_ctl = wr_any && (paddr[7:0] == `CIDI_OFS_CONTROL);
   assign wr_txerr = wr_any && (paddr[7:0] == `CIDI_OFS_TX_ERR);

   // Control bits drive the soft reset and the two status-change enables.
   assign can_soft_reset = control[`CIDI_CTL_SOFT_RESET];
   assign error_irq_en = control[`CIDI_CTL_ERROR_IRQ_EN];
   assign status_irq_en = control[`CIDI_CTL_STATUS_IRQ_EN];

   // ----------------------------------------------------------------------------
   // Message slots
   // ----------------------------------------------------------------------------
   // Slot n lives at bit n-1 of every slot vector; slot 15 never transmits.
   genvar g;
   generate
      for (g = 0; g < `CIDI_NUM_SLOTS; g = g + 1) begin : gen_slot
         // Each slot decodes its own write strobe from the shared slot number.
         assign slot_wr[g] = wr_any && in_slot_range && (slot_num == g + 1);
         cidi_slot #(
            .RX_ONLY((g == `CIDI_NUM_SLOTS - 1) ? 1 : 0)
         ) u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .soft_reset(can_soft_reset),
            .wr_en(slot_wr[g]),
            .wdata(pwdata[7:0]),
            .tx_done(slot_tx_done[g]),
            .rx_stored(slot_rx_stored[g]),
            .slot_ready(slot_ready[g]),
            .slot_tx_irq_en(slot_tx_en[g]),
            .slot_rx_irq_en(slot_rx_en[g]),
            .slot_irq_request(slot_req[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------------
   // The soft reset bit stays writable so software can release it again.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control <= `CIDI_RST_BYTE;
      end else if (wr_ctl) begin
         control <= pwdata[7:0];
      end
   end

   // Only bit five is used here; the other enables are kept for software.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extended_irq_enable <= `CIDI_RST_BYTE;
      end else if (wr_ext) begin
         extended_irq_enable <= pwdata[7:0];
      end
   end

   // Software copy of the transmit count; loading it also loads the receive count.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_error_count <= `CIDI_RST_BYTE;
      end else if (wr_txerr) begin
         tx_error_count <= pwdata[7:0];
      end
   end

   // ----------------------------------------------------------------------------
   // Receive error counter
   // ----------------------------------------------------------------------------
   // A software load takes precedence over a counted error in the same cycle.
   // The count saturates at the top rather than wrapping to a misleading small value.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_error_count <= `CIDI_RST_BYTE;
      end else if (can_soft_reset) begin
         rx_error_count <= `CIDI_RST_BYTE;
      end else if (wr_txerr) begin
         rx_error_count <= pwdata[7:0];
      end else if (rx_error_inc && (rx_error_count != 8'hFF)) begin
         rx_error_count <= rx_error_count + 8'h01;
      end
   end

   // ----------------------------------------------------------------------------
   // Status change interrupt state
   // ----------------------------------------------------------------------------
   // Only enabled kinds of change arm the state; a read of the status register
   // clears it, but a change in that very cycle re-arms it so nothing is lost.
   assign status_raise = (status_change_evt && status_irq_en) ||
                         (error_change_evt && error_irq_en);
   assign status_read = rd_access && (paddr[7:0] == `CIDI_OFS_STATUS);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_pending <= 1'b0;
      end else if (can_soft_reset) begin
         status_pending <= 1'b0;
      end else if (status_raise) begin
         status_pending <= 1'b1;
      end else if (status_read) begin
         status_pending <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // Priority selection
   // ----------------------------------------------------------------------------
   // Status change beats slot 15, which beats slots 1..14 in ascending order.
   always @* begin
      next_code = `CIDI_CODE_NONE;
      for (i_pri = `CIDI_NUM_SLOTS - 2; i_pri >= 0; i_pri = i_pri - 1) begin
         if (slot_req[i_pri]) begin
            next_code = `CIDI_CODE_SLOT1 + i_pri[7:0];
         end
      end
      if (slot_req[`CIDI_NUM_SLOTS - 1]) begin
         next_code = `CIDI_CODE_SLOT15;
      end
      if (status_pending) begin
         next_code = `CIDI_CODE_STATUS;
      end
   end

   // Is the source behind the displayed code still pending?
   always @* begin
      displayed_active = 1'b0;
      if (can_irq_source_code == `CIDI_CODE_STATUS) begin
         displayed_active = status_pending;
      end else if (can_irq_source_code == `CIDI_CODE_SLOT15) begin
         displayed_active = slot_req[`CIDI_NUM_SLOTS - 1];
      end else begin
         for (i_act = 0; i_act < `CIDI_NUM_SLOTS - 1; i_act = i_act + 1) begin
            if (can_irq_source_code == `CIDI_CODE_SLOT1 + i_act[7:0]) begin
               displayed_active = slot_req[i_act];
            end
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Indicator and interrupt outputs
   // ----------------------------------------------------------------------------
   // The displayed code is sticky: a newer, higher source waits until the shown
   // one is removed. Everything is registered so reads see a stable code.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_irq_source_code <= `CIDI_CODE_NONE;
      end else if (!displayed_active) begin
         can_irq_source_code <= next_code;
      end else begin
         can_irq_source_code <= can_irq_source_code;
      end
   end

   // Both request lines look at the registered code, never at the live sources.
   assign code_nonzero = (can_irq_source_code != `CIDI_CODE_NONE);

   // The request follows the registered code by one cycle, so it never glitches.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_irq_request <= 1'b0;
      end else begin
         can_irq_request <= code_nonzero;
      end
   end

   // The CAN B line is the same request gated by its enable; masking loses no source.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_b_irq <= 1'b0;
      end else begin
         can_b_irq <= code_nonzero && extended_irq_enable[`CIDI_EIE_CAN_B];
      end
   end

   // ----------------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------------
   // Slot registers show ready, enables and request in their documented bits.
   always @* begin
      rd_byte = 8'h00;
      rd_hit = 1'b1;
      case (paddr[7:0])
         `CIDI_OFS_SOURCE_CODE: begin
            rd_byte = can_irq_source_code;
         end
         `CIDI_OFS_RX_ERR: begin
            rd_byte = rx_error_count;
         end
         `CIDI_OFS_TX_ERR: begin
            rd_byte = tx_error_count;
         end
         `CIDI_OFS_CONTROL: begin
            rd_byte = control;
         end
         `CIDI_OFS_STATUS: begin
            rd_byte = can_status_reg;
         end
         `CIDI_OFS_EXT_IRQ_EN: begin
            rd_byte = extended_irq_enable;
         end
         default: begin
            // A slot register needs an aligned address; a stray byte address answers with pslverr.
            rd_hit = in_slot_range && (paddr[1:0] == 2'b00);
            for (i_rd = 0; i_rd < `CIDI_NUM_SLOTS; i_rd = i_rd + 1) begin
               if (in_slot_range && (slot_num == i_rd + 1)) begin
                  rd_byte[`CIDI_SLOT_READY] = slot_ready[i_rd];
                  rd_byte[`CIDI_SLOT_TX_EN] = slot_tx_en[i_rd];
                  rd_byte[`CIDI_SLOT_RX_EN] = slot_rx_en[i_rd];
                  rd_byte[`CIDI_SLOT_REQ] = slot_req[i_rd];
               end
            end
         end
      endcase
   end

   // Capture read data and the error answer in the setup cycle.
   // Unmapped addresses answer with pslverr and read as zero; a stray byte address in a slot word reads that slot.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= {24'h000000, rd_byte};
         pslverr <= !rd_hit;
      end
   end
endmodule // cidi_indicator

// *** rtl/cidi_unused_placeholder_removed.v ***
// Intentionally empty design unit list terminator.
`timescale 1ns/1ps

// *** dv/cidi_props.sv ***
// Concurrent checks on the ports of the CAN interrupt indicator.
`timescale 1ns/1ps
`include "cidi_consts.vh"
module cidi_props #(
   parameter ADDR_W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   input wire [14:0] slot_ready,
   input wire can_soft_reset,
   input wire can_irq_request,
   input wire can_b_irq
);
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   reg ext_en;
   // Shadow of the CAN B enable; it changes at the access edge, as the register does.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_en <= 1'b0;
      end else if (psel && penable && pwrite && pstrb[0] && paddr == `CIDI_OFS_EXT_IRQ_EN) begin
         ext_en <= pwdata[`CIDI_EIE_CAN_B];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------------------------------------------------------------
   // Sequences and assertions
   // ------------------------------------------------------------
   sequence src_read;
      psel && !penable && !pwrite && paddr == `CIDI_OFS_SOURCE_CODE;
   endsequence
   sequence reg_write(logic [7:0] a);
      psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   reset_quiet_a: assert property ($rose(presetn) |-> !can_irq_request && !can_b_irq)
      else $error("request high right after reset");
   irq_code_a: assert property (src_read ##1 1'b1 |-> can_irq_request == (prdata[7:0] != 8'h00))
      else $error("request disagrees with source code");
   code_range_a: assert property (src_read |=> prdata[7:0] <= 8'h10)
      else $error("source code out of range");
   b_gate_a: assert property (can_b_irq == (can_irq_request && $past(ext_en)))
      else $error("CAN B request not gated by enable");
   read_stable_a: assert property ((psel && penable) ##1 !psel |-> $stable(prdata))
      else $error("read data moved after access");
   soft_reset_a: assert property (reg_write(`CIDI_OFS_CONTROL) |=> can_soft_reset == $past(pwdata[0]))
      else $error("soft reset bit not written");
   ready_clear_a: assert property (can_soft_reset [*2] |-> slot_ready == 15'h0000)
      else $error("ready bits survive soft reset");
   ready_write_a: assert property (reg_write(`CIDI_OFS_SLOT_BASE) && !can_soft_reset |=>
      slot_ready[0] == $past(pwdata[`CIDI_SLOT_READY]))
      else $error("slot ready bit not written");
endmodule // cidi_props

bind cidi_indicator cidi_props #(.ADDR_W(ADDR_W)) i_cidi_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .slot_ready(slot_ready), .can_soft_reset(can_soft_reset),
   .can_irq_request(can_irq_request), .can_b_irq(can_b_irq));

// *** dv/cidi_engine_model.sv ***
// Behavioural CAN engine that raises event pulses on the far side of the block.
`timescale 1ns/1ps
module cidi_engine_model (
   input wire pclk,
   output logic [7:0] can_status_reg,
   output logic status_change_evt,
   output logic error_change_evt,
   output logic rx_error_inc,
   output logic [14:0] slot_tx_done,
   output logic [14:0] slot_rx_stored
);
   // Idle engine: no pulses and a fixed status byte.
   initial begin
      can_status_reg = 8'h18;
      status_change_evt = 1'b0;
      error_change_evt = 1'b0;
      rx_error_inc = 1'b0;
      slot_tx_done = 15'h0000;
      slot_rx_stored = 15'h0000;
   end
   // One-cycle pulse; slots are hit whether ready or not, gating is the block's job.
   task fire(input [2:0] kind, input [14:0] mask);
      begin
         @(posedge pclk);
         case (kind)
            3'h0: status_change_evt <= 1'b1;
            3'h1: error_change_evt <= 1'b1;
            3'h2: rx_error_inc <= 1'b1;
            3'h3: slot_tx_done <= mask;
            default: slot_rx_stored <= mask;
         endcase
         @(posedge pclk);
         status_change_evt <= 1'b0;
         error_change_evt <= 1'b0;
         rx_error_inc <= 1'b0;
         slot_tx_done <= 15'h0000;
         slot_rx_stored <= 15'h0000;
      end
   endtask
endmodule // cidi_engine_model

// *** dv/can_interrupt_indicator_test.sv ***
// Self-checking bench for the CAN interrupt indicator.
`timescale 1ns/1ps
`include "cidi_consts.vh"
module can_interrupt_indicator_test;
   localparam [7:0] a_src = `CIDI_OFS_SOURCE_CODE;
   localparam [7:0] a_ctl = `CIDI_OFS_CONTROL;
   localparam [7:0] a_rx = `CIDI_OFS_RX_ERR;
   localparam [7:0] a_ext = `CIDI_OFS_EXT_IRQ_EN;
   reg pclk, presetn, psel, penable, pwrite, last_err;
   reg [7:0] paddr;
   reg [31:0] pwdata, rdat;
   reg [3:0] pstrb;
   wire pready, pslverr, can_soft_reset, can_irq_request, can_b_irq;
   wire [31:0] prdata;
   wire [7:0] can_status_reg;
   wire status_change_evt, error_change_evt, rx_error_inc;
   wire [14:0] slot_tx_done, slot_rx_stored, slot_ready;
   integer n_errors, n_tests, i;
   cidi_indicator i_cidi_indicator (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .can_status_reg(can_status_reg),
      .status_change_evt(status_change_evt), .error_change_evt(error_change_evt),
      .rx_error_inc(rx_error_inc), .slot_tx_done(slot_tx_done),
      .slot_rx_stored(slot_rx_stored), .slot_ready(slot_ready),
      .can_soft_reset(can_soft_reset), .can_irq_request(can_irq_request),
      .can_b_irq(can_b_irq));
   cidi_engine_model i_cidi_engine_model (.pclk(pclk), .can_status_reg(can_status_reg),
      .status_change_evt(status_change_evt), .error_change_evt(error_change_evt),
      .rx_error_inc(rx_error_inc), .slot_tx_done(slot_tx_done),
      .slot_rx_stored(slot_rx_stored));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Ends the run with the counts and the verdict.
   task wrap_up;
      begin
         $display("tests %0d errors %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One APB transfer; an idle edge first keeps two transfers from touching in one step.
   task xfer(input [7:0] a, input w, input [31:0] d);
      integer k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         paddr <= a;
         pwrite <= w;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 50) begin
            k = k + 1;
            @(posedge pclk);
         end
         if (pready !== 1'b1) begin
            n_errors = n_errors + 1;
            $display("[ERR] %0t no ready", $time);
            wrap_up;
         end else begin
            rdat = prdata;
            last_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
         end
      end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
      begin
         xfer(a, 1'b0, 32'h00000000);
         chk(rdat, exp);
      end
   endtask
   function [7:0] slot_a(input integer n);
      slot_a = `CIDI_OFS_SLOT_BASE + 4 * (n - 1);
   endfunction
   // Clock and hang guard.
   always #50 pclk = ~pclk;
   initial begin
      #(100 * 50000);
      n_errors = n_errors + 1;
      $display("[ERR] %0t run too long", $time);
      wrap_up;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, last_err} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      n_errors = 0;
      n_tests = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(a_src, 32'h00);
      rd(a_ext, 32'h00);
      rd(slot_a(1), 32'h00);
      rd(8'hFC, 32'h00);
      chk(last_err, 32'h1);
      xfer(a_ext, 1'b1, 32'h20);
      xfer(a_ctl, 1'b1, 32'h06);
      for (i = 1; i <= 15; i = i + 1) xfer(slot_a(i), 1'b1, 32'hE0);
      // Every slot at once, then drain in priority order.
      i_cidi_engine_model.fire(3'h4, 15'h7FFF);
      repeat (3) @(posedge pclk);
      chk(can_b_irq, 32'h1);
      for (i = 0; i < 15; i = i + 1) begin
         rd(a_src, 2 + i);
         xfer(slot_a(i == 0 ? 15 : i), 1'b1, 32'hE0);
      end
      rd(a_src, 32'h00);
      // A higher source arriving later must wait its turn.
      i_cidi_engine_model.fire(3'h4, 15'h2000);
      i_cidi_engine_model.fire(3'h0, 15'h0000);
      rd(a_src, 32'h10);
      xfer(slot_a(14), 1'b1, 32'hE0);
      rd(a_src, 32'h01);
      rd(`CIDI_OFS_STATUS, 32'h18);
      rd(a_src, 32'h00);
      xfer(a_ctl, 1'b1, 32'h00);
      i_cidi_engine_model.fire(3'h0, 15'h0000);
      i_cidi_engine_model.fire(3'h1, 15'h0000);
      rd(a_src, 32'h00);
      xfer(a_ctl, 1'b1, 32'h02);
      rd(a_ctl, 32'h02);
      i_cidi_engine_model.fire(3'h1, 15'h0000);
      rd(a_src, 32'h01);
      rd(`CIDI_OFS_STATUS, 32'h18);
      rd(a_src, 32'h00);
      // Transmit enables and ready gating, with the CAN B enable off.
      xfer(a_ext, 1'b1, 32'h00);
      // A write with the low byte lane off must leave the enable alone.
      pstrb <= 4'hE;
      xfer(a_ext, 1'b1, 32'h20);
      pstrb <= 4'hF;
      rd(a_ext, 32'h00);
      i_cidi_engine_model.fire(3'h3, 15'h0004);
      repeat (3) @(posedge pclk);
      chk(can_irq_request, 32'h1);
      chk(can_b_irq, 32'h0);
      rd(a_src, 32'h05);
      xfer(slot_a(3), 1'b1, 32'hE0);
      i_cidi_engine_model.fire(3'h3, 15'h4000);
      rd(a_src, 32'h00);
      xfer(slot_a(2), 1'b1, 32'hA0);
      i_cidi_engine_model.fire(3'h3, 15'h0002);
      rd(a_src, 32'h00);
      xfer(slot_a(5), 1'b1, 32'h60);
      i_cidi_engine_model.fire(3'h4, 15'h0010);
      rd(a_src, 32'h00);
      chk(can_irq_request, 32'h0);
      // Receive error count: increments, load, soft reset.
      for (i = 0; i < 3; i = i + 1) i_cidi_engine_model.fire(3'h2, 15'h0000);
      rd(a_rx, 32'h03);
      xfer(`CIDI_OFS_TX_ERR, 1'b1, 32'h5A);
      rd(a_rx, 32'h5A);
      rd(`CIDI_OFS_TX_ERR, 32'h5A);
      xfer(a_ctl, 1'b1, 32'h01);
      rd(a_rx, 32'h00);
      chk({17'h00000, slot_ready}, 32'h0);
      chk(can_soft_reset, 32'h1);
      xfer(a_ctl, 1'b1, 32'h00);
      rd(slot_a(1), 32'h00);
      chk(can_soft_reset, 32'h0);
      wrap_up;
   end
endmodule // can_interrupt_indicator_test
